//--- hdl/bond_encoder.sv
// Master-side bond state encoder and open-drain drive control
`default_nettype none
module bond_encoder
    import xcvr_ctl_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Channel choice and drive permission
    input wire logic sel_b,
    input wire logic sel_d,
    input wire logic drive_en,
    // Elastic buffer events per channel
    input wire logic [NUM_CH-1:0] word_sync,
    input wire logic [NUM_CH-1:0] eb_insert,
    input wire logic [NUM_CH-1:0] eb_delete,
    // Registered result
    output bond_code_t code,
    output logic [1:0] pin_oe
);
    logic [1:0] ch;
    bond_code_t code_nxt;
    bond_code_t code_r;
    logic [1:0] oe_r;

    assign ch = {sel_d, sel_b};

    // Sync outranks buffer adjustments, so slaves realign first
    always_comb begin
        if (word_sync[ch]) begin
            code_nxt = BOND_SYNC;
        end else if (eb_insert[ch]) begin
            code_nxt = BOND_INSERT;
        end else if (eb_delete[ch]) begin
            code_nxt = BOND_DELETE;
        end else begin
            code_nxt = BOND_NORMAL;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            code_r <= BOND_NORMAL;
        end else begin
            code_r <= code_nxt;
        end
    end

    // Open drain: pull low for a zero bit only while allowed to drive
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            oe_r <= 2'h0;
        end else if (drive_en) begin
            oe_r <= ~code_nxt;
        end else begin
            oe_r <= 2'h0;
        end
    end

    assign code = code_r;
    assign pin_oe = oe_r;
endmodule
`default_nettype wire

//--- hdl/enable_latch.sv
// Clocked stand-in for one transparent enable latch fed by the shared bus
`default_nettype none
module enable_latch
    import xcvr_ctl_pkg::*;
#(
    parameter logic [7:0] RST_VAL = 8'hff
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic dev_reset_n,
    // Bus side
    input wire logic latch_open,
    input wire logic [7:0] enable_bus,
    // Held value
    output logic [7:0] q
);
    logic [7:0] q_r;

    // Open follows the bus, closed holds; device reset acts only when closed
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q_r <= RST_VAL;
        end else if (latch_open) begin
            q_r <= enable_bus;
        end else if (!dev_reset_n) begin
            q_r <= RST_VAL;
        end
    end

    assign q = q_r;

    a_latch_follows: assert property (
        @(posedge aclk) disable iff (!aresetn)
        latch_open |=> q_r == $past(enable_bus))
        else $error("latch did not follow the bus while open");
    a_latch_holds: assert property (
        @(posedge aclk) disable iff (!aresetn)
        !latch_open && dev_reset_n |=> $stable(q_r))
        else $error("closed latch changed value");
endmodule
`default_nettype wire

//--- hdl/xcvr_ctl_pkg.sv
// Shared constants and types for the transceiver control and status block
`default_nettype none
package xcvr_ctl_pkg;
    // ********************************
    // Sizes
    // ********************************
    localparam int NUM_CH = 4;
    localparam int ADDR_W = 12;
    localparam int RX_EN_STRIDE = 2;

    // ********************************
    // Latch reset values
    // ********************************
    // Drivers enabled, self-test off (high = normal), receivers powered
    localparam logic [7:0] DRIVE_RST = 8'hff;
    localparam logic [7:0] SELFTEST_RST = 8'hff;
    localparam logic [7:0] RXPWR_RST = 8'hff;

    // ********************************
    // Multi-chip bond state codes
    // ********************************
    typedef enum logic [1:0] {
        BOND_SYNC = 2'h0,
        BOND_INSERT = 2'h1,
        BOND_DELETE = 2'h2,
        BOND_NORMAL = 2'h3
    } bond_code_t;

    // ********************************
    // Register map
    // ********************************
    localparam logic [ADDR_W-1:0] OFS_LATCH = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_LINK = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 12'h008;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 12'h00c;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 12'h010;
    localparam int FLD_DRIVE_LSB = 0;
    localparam int FLD_SELFTEST_LSB = 8;
    localparam int FLD_RXPWR_LSB = 16;
    localparam int FLD_FAULT_LSB = 0;
    localparam int FLD_BONDRX_LSB = 4;
    localparam int FLD_BONDDRV_BIT = 6;
    localparam int IRQ_BOND_BIT = 4;
    localparam int CTRL_ALLOW_BIT = 0;
    localparam logic [4:0] IRQ_MASK_RST = 5'h00;
    localparam logic CTRL_ALLOW_RST = 1'b1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

//--- hdl/xcvr_ctl_top.sv
// Enable latches, link fault outputs and multi-chip bond state pins
// Operation
// - The drive latch follows the enable bus while open, then holds.
// - The self-test latch follows the enable bus while open, then holds.
// - The receive power latch follows the enable bus while open, then holds.
// - Each receive channel has its own active-low link fault output.
// - A fault shows on frequency, amplitude, density or channel disabled.
// - The channel-disabled fault term passes with no synchroniser.
// - The bond state bus serves only bonded multi-device setups.
// - Bond state pins change with the receive parallel output timing.
// - The master encodes the buffer state of the channel two pins select.
// - Codes: 00 sync, 01 insert, 10 delete, 11 normal data.
// - Bond pins are driven only as master, all bonded, on reference clock.
// - A high drive latch bit enables a driver; device reset re-enables all while the latch is closed.
// - A low self-test latch bit runs the test sequence, high is normal.
// - The active-low primary select makes this device the bond master.
`default_nettype none
module xcvr_ctl_top
    import xcvr_ctl_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write
    input wire logic awvalid,
    output logic awready,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read
    input wire logic arvalid,
    output logic arready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // Interrupt
    output logic irq,
    // Enable latches
    input wire logic [7:0] shared_enable_bus,
    input wire logic drive_latch_open,
    input wire logic selftest_latch_open,
    input wire logic rx_power_latch_open,
    input wire logic test_and_device_reset_n,
    output logic [7:0] serial_drive_en,
    output logic [7:0] selftest_en_n,
    output logic [NUM_CH-1:0] rx_channel_en,
    // Link quality conditions and fault outputs
    input wire logic [NUM_CH-1:0] freq_out_of_range,
    input wire logic [NUM_CH-1:0] amplitude_low,
    input wire logic [NUM_CH-1:0] density_low,
    output logic link_fault_n_a,
    output logic link_fault_n_b,
    output logic link_fault_n_c,
    output logic link_fault_n_d,
    // Bonding
    input wire logic primary_select_n,
    input wire logic all_channels_bonded,
    input wire logic rx_clock_is_ref,
    input wire logic primary_channel_sel_b,
    input wire logic primary_channel_sel_d,
    input wire logic [NUM_CH-1:0] word_sync_seen,
    input wire logic [NUM_CH-1:0] eb_insert_req,
    input wire logic [NUM_CH-1:0] eb_delete_req,
    input wire logic [1:0] multichip_bond_state_i,
    output logic [1:0] multichip_bond_state_o,
    output logic [1:0] multichip_bond_state_oe,
    output logic [1:0] bond_state_seen
);
    // ********************************
    // Enable latches
    // ********************************
    logic [7:0] drive_q;
    logic [7:0] selftest_q;
    logic [7:0] rxpwr_q;
    logic [NUM_CH-1:0] rx_en;

    enable_latch #(.RST_VAL(DRIVE_RST)) u_drive (
        .aclk(aclk),
        .aresetn(aresetn),
        .dev_reset_n(test_and_device_reset_n),
        .latch_open(drive_latch_open),
        .enable_bus(shared_enable_bus),
        .q(drive_q)
    );

    // Self-test enable latch, low bit selects the test
    enable_latch #(.RST_VAL(SELFTEST_RST)) u_selftest (
        .aclk(aclk),
        .aresetn(aresetn),
        .dev_reset_n(test_and_device_reset_n),
        .latch_open(selftest_latch_open),
        .enable_bus(shared_enable_bus),
        .q(selftest_q)
    );

    enable_latch #(.RST_VAL(RXPWR_RST)) u_rxpwr (
        .aclk(aclk),
        .aresetn(aresetn),
        .dev_reset_n(test_and_device_reset_n),
        .latch_open(rx_power_latch_open),
        .enable_bus(shared_enable_bus),
        .q(rxpwr_q)
    );

    assign serial_drive_en = drive_q;
    assign selftest_en_n = selftest_q;

    // ********************************
    // Link fault per channel
    // ********************************
    logic [NUM_CH-1:0] fault_n_r;
    logic [NUM_CH-1:0] fault_q;
    logic [NUM_CH-1:0] fault_rise;

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            assign rx_en[g] = rxpwr_q[g*RX_EN_STRIDE];
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    fault_n_r[g] <= 1'b1;
                end else begin
                    fault_n_r[g] <= !(freq_out_of_range[g] ||
                        amplitude_low[g] || density_low[g] || !rx_en[g]);
                end
            end
            assign fault_rise[g] = !fault_n_r[g] && !fault_q[g];
        end
    endgenerate

    assign rx_channel_en = rx_en;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fault_q <= '0;
        end else begin
            fault_q <= ~fault_n_r;
        end
    end

    assign link_fault_n_a = fault_n_r[0];
    assign link_fault_n_b = fault_n_r[1];
    assign link_fault_n_c = fault_n_r[2];
    assign link_fault_n_d = fault_n_r[3];

    // ********************************
    // Bond state bus
    // ********************************
    logic ctrl_allow_r;
    logic bond_drive;
    logic [1:0] bond_oe;
    logic [1:0] bond_o_r;
    logic [1:0] bond_rx_r;
    logic [1:0] bond_rx_q;

    // Drive only as master, fully bonded, on ref clock
    assign bond_drive = !primary_select_n && all_channels_bonded &&
        rx_clock_is_ref && ctrl_allow_r;

    // One register stage, same as the rx data path
    bond_encoder u_bond (
        .aclk(aclk),
        .aresetn(aresetn),
        .sel_b(primary_channel_sel_b),
        .sel_d(primary_channel_sel_d),
        .drive_en(bond_drive),
        .word_sync(word_sync_seen),
        .eb_insert(eb_insert_req),
        .eb_delete(eb_delete_req),
        .code(),
        .pin_oe(bond_oe)
    );

    // Pin value is always low; only the enables carry the code
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bond_o_r <= 2'h0;
        end else begin
            bond_o_r <= 2'h0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bond_rx_r <= BOND_NORMAL;
            bond_rx_q <= BOND_NORMAL;
        end else begin
            bond_rx_r <= multichip_bond_state_i;
            bond_rx_q <= bond_rx_r;
        end
    end

    assign multichip_bond_state_o = bond_o_r;
    assign multichip_bond_state_oe = bond_oe;
    assign bond_state_seen = bond_rx_r;

    // ********************************
    // AXI4-Lite slave
    // ********************************
    logic awready_r;
    logic wready_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic arready_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic [ADDR_W-1:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic wr_go;
    logic rd_go;
    logic [4:0] irq_mask_r;
    logic [4:0] irq_mask_nxt;
    logic [4:0] irq_stat_r;
    logic [4:0] irq_stat_nxt;
    logic irq_r;

    // Address and data may arrive in either order; both must be held
    assign wr_go = !awready_r && !wready_r && !bvalid_r;
    assign rd_go = arvalid && arready_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_r <= 1'b1;
        end else if (awvalid && awready_r) begin
            awready_r <= 1'b0;
        end else if (bvalid_r && bready) begin
            awready_r <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_addr_r <= '0;
        end else if (awvalid && awready_r) begin
            aw_addr_r <= awaddr;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready_r <= 1'b1;
        end else if (wvalid && wready_r) begin
            wready_r <= 1'b0;
        end else if (bvalid_r && bready) begin
            wready_r <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_data_r <= '0;
            w_strb_r <= '0;
        end else if (wvalid && wready_r) begin
            w_data_r <= wdata;
            w_strb_r <= wstrb;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid_r <= 1'b1;
            if (aw_addr_r == OFS_IRQ_MASK || aw_addr_r == OFS_CTRL) begin
                bresp_r <= RESP_OKAY;
            end else begin
                bresp_r <= RESP_SLVERR;
            end
        end else if (bvalid_r && bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // Only the low byte holds writable bits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_mask_r <= IRQ_MASK_RST;
            ctrl_allow_r <= CTRL_ALLOW_RST;
        end else if (wr_go && w_strb_r[0]) begin
            if (aw_addr_r == OFS_IRQ_MASK) begin
                irq_mask_r <= w_data_r[4:0];
            end
            if (aw_addr_r == OFS_CTRL) begin
                ctrl_allow_r <= w_data_r[CTRL_ALLOW_BIT];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b1;
        end else if (rd_go) begin
            arready_r <= 1'b0;
        end else if (rvalid_r && rready) begin
            arready_r <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= RESP_OKAY;
        end else if (rd_go) begin
            rvalid_r <= 1'b1;
            rresp_r <= RESP_OKAY;
            rdata_r <= '0;
            case (araddr)
                OFS_LATCH: begin
                    rdata_r[FLD_DRIVE_LSB +: 8] <= drive_q;
                    rdata_r[FLD_SELFTEST_LSB +: 8] <= selftest_q;
                    rdata_r[FLD_RXPWR_LSB +: 8] <= rxpwr_q;
                end
                OFS_LINK: begin
                    rdata_r[FLD_FAULT_LSB +: NUM_CH] <= ~fault_n_r;
                    rdata_r[FLD_BONDRX_LSB +: 2] <= bond_rx_r;
                    rdata_r[FLD_BONDDRV_BIT] <= |bond_oe;
                end
                OFS_IRQ_STAT: begin
                    rdata_r[4:0] <= irq_stat_r;
                end
                OFS_IRQ_MASK: begin
                    rdata_r[4:0] <= irq_mask_r;
                end
                OFS_CTRL: begin
                    rdata_r[CTRL_ALLOW_BIT] <= ctrl_allow_r;
                end
                default: begin
                    rresp_r <= RESP_SLVERR;
                end
            endcase
        end else if (rvalid_r && rready) begin
            rvalid_r <= 1'b0;
        end
    end

    assign awready = awready_r;
    assign wready = wready_r;
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign arready = arready_r;
    assign rvalid = rvalid_r;
    assign rdata = rdata_r;
    assign rresp = rresp_r;

    // ********************************
    // Interrupt status
    // ********************************
    // Read clears, but an event in the same cycle survives the clear
    always_comb begin
        irq_stat_nxt = irq_stat_r;
        if (rd_go && araddr == OFS_IRQ_STAT) begin
            irq_stat_nxt = 5'h00;
        end
        irq_stat_nxt[NUM_CH-1:0] = irq_stat_nxt[NUM_CH-1:0] | fault_rise;
        irq_stat_nxt[IRQ_BOND_BIT] = irq_stat_nxt[IRQ_BOND_BIT] |
            (bond_rx_r != bond_rx_q);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_r <= 5'h00;
            irq_r <= 1'b0;
        end else begin
            irq_stat_r <= irq_stat_nxt;
            irq_r <= |(irq_stat_nxt & irq_mask_nxt);
        end
    end

    // A mask write reaches irq on the same edge, so irq never lags the mask
    assign irq_mask_nxt = (wr_go && w_strb_r[0] && aw_addr_r == OFS_IRQ_MASK)
        ? w_data_r[4:0] : irq_mask_r;

    assign irq = irq_r;

    // ********************************
    // Checks
    // ********************************
    a_drive_follow: assert property (@(posedge aclk) disable iff (!aresetn)
        drive_latch_open |=> serial_drive_en == $past(shared_enable_bus))
        else $error("drive latch did not pass the bus");
    a_selftest_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        $fell(selftest_latch_open) && test_and_device_reset_n
        |=> selftest_en_n == $past(selftest_en_n))
        else $error("self-test latch lost its captured value");
    a_rxpwr_follow: assert property (@(posedge aclk) disable iff (!aresetn)
        rx_power_latch_open ##1 rx_power_latch_open
        |-> rx_channel_en[0] == $past(shared_enable_bus[0]))
        else $error("receive power latch did not follow");
    a_fault_cause: assert property (@(posedge aclk) disable iff (!aresetn)
        freq_out_of_range[1] || amplitude_low[1] || density_low[1]
        |=> !link_fault_n_b)
        else $error("link fault missing for a bad condition");
    a_fault_disable: assert property (@(posedge aclk) disable iff (!aresetn)
        !rx_channel_en[2] |=> !link_fault_n_c)
        else $error("disabled channel shows no link fault");
    a_fault_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        rx_channel_en[0] && !freq_out_of_range[0] && !amplitude_low[0]
        && !density_low[0] |=> link_fault_n_a)
        else $error("link fault set with no cause");
    a_bond_release: assert property (@(posedge aclk) disable iff (!aresetn)
        primary_select_n |=> multichip_bond_state_oe == 2'h0)
        else $error("slave device drove the bond lines");
    a_bond_code: assert property (@(posedge aclk) disable iff (!aresetn)
        bond_drive && word_sync_seen[{primary_channel_sel_d,
        primary_channel_sel_b}] |=> multichip_bond_state_oe == 2'h3)
        else $error("sync code not driven as 00");
    a_bond_gate: assert property (@(posedge aclk) disable iff (!aresetn)
        !all_channels_bonded || !rx_clock_is_ref
        |=> multichip_bond_state_oe == 2'h0)
        else $error("bond lines driven outside bonded reference mode");
    a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
        irq == |(irq_stat_r & irq_mask_r))
        else $error("interrupt output disagrees with status and mask");
endmodule
`default_nettype wire

//--- testbench/bond_bus_model.sv
// Open-drain bond state wires with pull-ups and another master on the far side
`default_nettype none
module bond_bus_model (
    // Pull-low enables of every party
    input wire logic [1:0] dut_oe,
    input wire logic [1:0] other_pull,
    // Resolved wire level
    output logic [1:0] level
);
    timeunit 1ns;
    timeprecision 1ps;
    assign level = ~(dut_oe | other_pull);
endmodule
`default_nettype wire

//--- testbench/channel_enable_fault_bond_status_bench.sv
// Register-bus driven bench of the enable latches, faults and bond pins
`default_nettype none
module channel_enable_fault_bond_status_bench
    import xcvr_ctl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic [2:0] awprot = 3'h0, arprot = 3'h0;
    logic [3:0] wstrb = 4'hf;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp, rs, other_pull = 2'h0;
    logic [7:0] shared_enable_bus = 8'hff, serial_drive_en, selftest_en_n;
    logic drive_latch_open = 1'h0, selftest_latch_open = 1'h0;
    logic rx_power_latch_open = 1'h0, test_and_device_reset_n = 1'h1;
    logic primary_select_n = 1'h1, all_channels_bonded = 1'h0;
    logic rx_clock_is_ref = 1'h0;
    logic primary_channel_sel_b = 1'h0, primary_channel_sel_d = 1'h0;
    logic [3:0] freq_out_of_range = 4'h0, amplitude_low = 4'h0;
    logic [3:0] density_low = 4'h0, word_sync_seen = 4'h0;
    logic [3:0] eb_insert_req = 4'h0, eb_delete_req = 4'h0;
    logic [3:0] rx_channel_en, lf;
    logic link_fault_n_a, link_fault_n_b, link_fault_n_c, link_fault_n_d;
    logic [1:0] multichip_bond_state_i, multichip_bond_state_o;
    logic [1:0] multichip_bond_state_oe, bond_state_seen;
    int miscompares = 0;
    int samples_checked = 0;
    int i;

    assign lf = {link_fault_n_d, link_fault_n_c, link_fault_n_b, link_fault_n_a};
    always #2.5 aclk = ~aclk;

    xcvr_ctl_top i_dut (.*);
    bond_bus_model i_wire (
        .dut_oe(multichip_bond_state_oe),
        .other_pull(other_pull),
        .level(multichip_bond_state_i)
    );

    // ****************************************
    // Bus tasks and checks
    // ****************************************
    task automatic wrap_up();
        if (miscompares == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, g);
        samples_checked++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
            miscompares++;
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask

    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
        int n;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
            if (bvalid) break;
        end
        if (n == 50) begin
            miscompares++;
            wrap_up();
        end
        rs = bresp;
    endtask

    task automatic axi_rd(input logic [11:0] a);
        int n;
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'h0;
            if (rvalid) break;
        end
        if (n == 50) begin
            miscompares++;
            wrap_up();
        end
        rd = rdata;
        rs = rresp;
    endtask

    task automatic latch_load(input logic [2:0] opn, input logic [7:0] v);
        shared_enable_bus <= v;
        {drive_latch_open, selftest_latch_open, rx_power_latch_open} <= opn;
        tick(2);
        {drive_latch_open, selftest_latch_open, rx_power_latch_open} <= 3'h0;
        shared_enable_bus <= ~v;
        tick(3);
    endtask

    initial begin
        tick(2);
        aresetn <= 1'h1;
        axi_rd(OFS_LATCH);
        chk("latches", 32'h00ffffff, rd);
        axi_rd(OFS_LINK);
        chk("link", 32'h30, rd);
        axi_rd(12'h020);
        chk("rresp", RESP_SLVERR, rs);
        chk("rdata", 32'h0, rd);
        axi_wr(OFS_LATCH, 32'h0);
        chk("bresp", RESP_SLVERR, rs);
        latch_load(3'h4, 8'ha5);
        latch_load(3'h2, 8'h3c);
        latch_load(3'h1, 8'hee);
        axi_rd(OFS_LATCH);
        chk("latches", 32'h00ee3ca5, rd);
        chk("selftest", 8'h3c, selftest_en_n);
        chk("rx_en", 4'ha, rx_channel_en);
        chk("fault", 4'ha, lf);
        test_and_device_reset_n <= 1'h0;
        tick(1);
        test_and_device_reset_n <= 1'h1;
        tick(2);
        chk("drive", 8'hff, serial_drive_en);
        chk("fault", 4'hf, lf);
        for (i = 0; i < 4; i++) begin
            freq_out_of_range <= (i % 3 == 0) ? 4'h1 << i : 4'h0;
            amplitude_low <= (i % 3 == 1) ? 4'h1 << i : 4'h0;
            density_low <= (i % 3 == 2) ? 4'h1 << i : 4'h0;
            tick(3);
            chk("fault", {28'h0, ~(4'h1 << i)}, lf);
        end
        {freq_out_of_range, amplitude_low, density_low} <= 12'h0;
        tick(3);
        axi_rd(OFS_IRQ_STAT);
        chk("status", 32'hf, rd);
        axi_wr(OFS_IRQ_MASK, 32'h1);
        chk("bresp", RESP_OKAY, rs);
        density_low <= 4'h2;
        tick(4);
        chk("irq", 1'h0, irq);
        axi_wr(OFS_IRQ_MASK, 32'h2);
        tick(2);
        chk("irq", 1'h1, irq);
        axi_rd(OFS_IRQ_STAT);
        chk("status", 32'h2, rd);
        tick(2);
        chk("irq", 1'h0, irq);
        density_low <= 4'h0;
        primary_select_n <= 1'h0;
        all_channels_bonded <= 1'h1;
        rx_clock_is_ref <= 1'h1;
        primary_channel_sel_d <= 1'h1;
        for (i = 0; i < 4; i++) begin
            word_sync_seen <= (i == 0) ? 4'h4 : 4'h0;
            eb_insert_req <= (i == 1) ? 4'h6 : 4'h2;
            eb_delete_req <= (i == 2) ? 4'h4 : 4'h0;
            tick(3);
            chk("oe", {30'h0, ~i[1:0]}, multichip_bond_state_oe);
            chk("wire", i, multichip_bond_state_i);
            chk("seen", i, bond_state_seen);
        end
        eb_delete_req <= 4'h4;
        rx_clock_is_ref <= 1'h0;
        tick(3);
        chk("oe", 2'h0, multichip_bond_state_oe);
        rx_clock_is_ref <= 1'h1;
        axi_wr(OFS_CTRL, 32'h0);
        tick(2);
        chk("oe", 2'h0, multichip_bond_state_oe);
        axi_wr(OFS_CTRL, 32'h1);
        primary_select_n <= 1'h1;
        other_pull <= 2'h2;
        tick(3);
        chk("oe", 2'h0, multichip_bond_state_oe);
        chk("seen", 2'h1, bond_state_seen);
        chk("pin", 2'h0, multichip_bond_state_o);
        wrap_up();
    end
endmodule
`default_nettype wire
